// ==== rtl/lsil_indicator.sv ====
/*
  Status indicator logic of an optical Ethernet transmission unit:
  participant, optical link, link error and wired link LEDs, received
  level bargraph, quality warning output and transmit gating.
  Assumes all inputs synchronous to i_clk and a plain register port.
*/
`timescale 1ns/1ps

// Contract
// - Waiting for fieldbus reconnection, no exchange: participant LED flashes green.
// - Fieldbus communication up and cyclic exchange: participant LED steady green.
// - Identification blink: supply and participant LEDs flash orange in phase.
// - Parameterization or configuration failed: participant LED flashes red.
// - Bus error without controller communication: participant LED steady red.
// - No optical connection or any transmitter deactivated: optical LED dark.
// - Optical link present: green when idle, orange during traffic.
// - Remote missing wired link or remote bar without orange: error LED orange.
// - Own wired link missing or own bar without orange: error LED red.
// - Wired LED dark without link, green idle, orange with traffic.
// - Eight bargraph segments: two red, two orange, four green.
// - Contiguous bar; falling level extinguishes green segments first.
// - Lit green segments mean reserve and an existing optical link.
// - Orange top segment warns; self-running mode keeps transmission on.
// - Hand-set or alignment mode disables transmission at orange level.
// - Orange level in the three modes asserts the quality warning output.
// - Only red lit: link interrupted, no data, warning output asserted.
// - Own level is passed to the remote unit; remote level displayable.
module lsil_indicator #(
  parameter int LEVEL_W = 8,
  parameter int FLASH_HALF_CYC = lsil_pkg::FLASH_HALF_CYC,
  parameter int ACT_STRETCH_CYC = lsil_pkg::ACT_STRETCH_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  input wire logic i_bus_waiting,
  input wire logic i_bus_exchange,
  input wire logic i_bus_cfg_fail,
  input wire logic i_bus_error,
  input wire logic i_ident_blink,
  input wire logic i_tx_disabled,
  input wire logic i_remote_tx_disabled,
  input wire logic i_opt_activity,
  input wire logic i_phy_link,
  input wire logic i_phy_activity,
  input wire logic [LEVEL_W-1:0] i_rx_level,
  input wire logic [7:0] i_remote_level,
  input wire logic i_remote_phy_link,
  output lsil_pkg::lsil_colour_t o_supply_led,
  output lsil_pkg::lsil_colour_t o_participant_led,
  output lsil_pkg::lsil_colour_t o_optical_connection_led,
  output lsil_pkg::lsil_colour_t o_link_error_led,
  output lsil_pkg::lsil_colour_t o_wired_link_led,
  output logic [7:0] o_receive_level_bargraph,
  output logic [7:0] o_level_to_remote,
  output logic o_quality_warning_output,
  output logic o_data_tx_enable
);

  lsil_pkg::lsil_mode_t mode;
  logic show_remote;
  logic [LEVEL_W-1:0] thr [lsil_pkg::SEG_COUNT];
  logic [LEVEL_W-1:0] hyst;
  logic [7:0] bar;
  logic [31:0] flash_cnt;
  logic flash_phase;
  logic [31:0] act_cnt [2];
  logic [1:0] act_seen;

  // Register decode
  wire wr_ctrl = i_wr_en && (i_addr == lsil_pkg::REG_CTRL);
  wire wr_hyst = i_wr_en && (i_addr == lsil_pkg::REG_HYST);
  wire [7:0] thr_off = i_addr - lsil_pkg::REG_THR_BASE;
  wire in_thr = (i_addr >= lsil_pkg::REG_THR_BASE) && (i_addr < lsil_pkg::REG_HYST) && (i_addr[1:0] == 2'b00);
  wire [2:0] thr_idx = thr_off[4:2];
  wire wr_thr = i_wr_en && in_thr;

  // Bargraph state
  wire link_ok = bar[lsil_pkg::SEG_FIRST_ORANGE];
  wire green_lit = bar[lsil_pkg::SEG_FIRST_GREEN];
  wire orange_top = link_ok && !green_lit;
  wire red_only = !link_ok;
  wire remote_link_ok = i_remote_level[lsil_pkg::SEG_FIRST_ORANGE];
  wire warn_mode = (mode != lsil_pkg::MODE_OTHER);
  wire next_warn = (orange_top && warn_mode) || red_only;
  wire next_tx_en = !red_only && (green_lit || (mode == lsil_pkg::MODE_SELF_RUNNING));

  // Segment compare with hysteresis, forced contiguous
  logic [7:0] raw_seg;
  logic [7:0] next_bar;
  for (genvar i = 0; i < lsil_pkg::SEG_COUNT; i++) begin : g_seg
    wire [LEVEL_W:0] lvl_up = {1'b0, i_rx_level} + {1'b0, hyst};
    wire [LEVEL_W:0] thr_ext = {1'b0, thr[i]};
    assign raw_seg[i] = bar[i] ? (lvl_up >= thr_ext) : ({1'b0, i_rx_level} >= thr_ext);
    if (i == 0) begin : g_first
      assign next_bar[i] = raw_seg[i];
    end else begin : g_rest
      assign next_bar[i] = raw_seg[i] && next_bar[i-1];
    end
    wire [LEVEL_W-1:0] thr_rst = LEVEL_W'((i + 1) * lsil_pkg::THR_STEP_RST);
    wire thr_hit = wr_thr && (thr_idx == 3'(i));
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        thr[i] <= thr_rst;
      end else if (thr_hit) begin
        thr[i] <= i_wr_data[LEVEL_W-1:0];
      end
    end
  end

  // Activity stretchers, optical (0) and wired (1)
  wire [1:0] act_in = {i_phy_activity, i_opt_activity};
  for (genvar a = 0; a < 2; a++) begin : g_act
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        act_cnt[a] <= 32'h0;
      end else if (act_in[a]) begin
        act_cnt[a] <= 32'(ACT_STRETCH_CYC);
      end else if (act_cnt[a] != 32'h0) begin
        act_cnt[a] <= act_cnt[a] - 32'h1;
      end
    end
    assign act_seen[a] = act_in[a] || (act_cnt[a] != 32'h0);
  end

  // Participant LED priority: red, then orange, then green
  lsil_pkg::lsil_colour_t flash_green;
  lsil_pkg::lsil_colour_t flash_orange;
  lsil_pkg::lsil_colour_t flash_red;
  lsil_pkg::lsil_colour_t next_part;
  lsil_pkg::lsil_colour_t next_supply;
  lsil_pkg::lsil_colour_t next_opt;
  lsil_pkg::lsil_colour_t next_err;
  lsil_pkg::lsil_colour_t next_wired;
  assign flash_green = flash_phase ? lsil_pkg::COL_GREEN : lsil_pkg::COL_OFF;
  assign flash_orange = flash_phase ? lsil_pkg::COL_ORANGE : lsil_pkg::COL_OFF;
  assign flash_red = flash_phase ? lsil_pkg::COL_RED : lsil_pkg::COL_OFF;

  always_comb begin
    if (i_bus_cfg_fail) begin
      next_part = flash_red;
    end else if (i_bus_error) begin
      next_part = lsil_pkg::COL_RED;
    end else if (i_ident_blink) begin
      next_part = flash_orange;
    end else if (i_bus_exchange) begin
      next_part = lsil_pkg::COL_GREEN;
    end else if (i_bus_waiting) begin
      next_part = flash_green;
    end else begin
      next_part = lsil_pkg::COL_OFF;
    end
  end

  assign next_supply = i_ident_blink ? flash_orange : lsil_pkg::COL_GREEN;

  always_comb begin
    if (!link_ok || i_tx_disabled || i_remote_tx_disabled) begin
      next_opt = lsil_pkg::COL_OFF;
    end else if (act_seen[0]) begin
      next_opt = lsil_pkg::COL_ORANGE;
    end else begin
      next_opt = lsil_pkg::COL_GREEN;
    end
  end

  always_comb begin
    if (!i_phy_link || !link_ok) begin
      next_err = lsil_pkg::COL_RED;
    end else if (!i_remote_phy_link || !remote_link_ok) begin
      next_err = lsil_pkg::COL_ORANGE;
    end else begin
      next_err = lsil_pkg::COL_OFF;
    end
  end

  always_comb begin
    if (!i_phy_link) begin
      next_wired = lsil_pkg::COL_OFF;
    end else if (act_seen[1]) begin
      next_wired = lsil_pkg::COL_ORANGE;
    end else begin
      next_wired = lsil_pkg::COL_GREEN;
    end
  end

  // Read mux
  wire sel_ctrl = (i_addr == lsil_pkg::REG_CTRL);
  wire sel_hyst = (i_addr == lsil_pkg::REG_HYST);
  wire sel_status = (i_addr == lsil_pkg::REG_STATUS);
  wire sel_remote = (i_addr == lsil_pkg::REG_REMOTE);
  wire [31:0] ctrl_word = {29'h0, show_remote, mode};
  wire [31:0] status_word = {21'h0, o_data_tx_enable, o_quality_warning_output, link_ok, bar};
  wire [31:0] thr_word = {{(32 - LEVEL_W){1'b0}}, thr[thr_idx]};
  wire [31:0] hyst_word = {{(32 - LEVEL_W){1'b0}}, hyst};
  wire [31:0] remote_word = {24'h0, i_remote_level};
  wire [31:0] next_rd_data =
    sel_ctrl ? ctrl_word :
    in_thr ? thr_word :
    sel_hyst ? hyst_word :
    sel_status ? status_word :
    sel_remote ? remote_word :
    32'h0;
  wire [31:0] rd_word = i_rd_en ? next_rd_data : 32'h0;

  // Control registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode <= lsil_pkg::MODE_RST;
    end else if (wr_ctrl) begin
      mode <= lsil_pkg::lsil_mode_t'(i_wr_data[lsil_pkg::CTRL_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      show_remote <= 1'b0;
    end else if (wr_ctrl) begin
      show_remote <= i_wr_data[lsil_pkg::CTRL_SHOW_REMOTE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hyst <= LEVEL_W'(lsil_pkg::HYST_RST);
    end else if (wr_hyst) begin
      hyst <= i_wr_data[LEVEL_W-1:0];
    end
  end

  // Shared flash timebase
  wire flash_wrap = (flash_cnt >= 32'(FLASH_HALF_CYC - 1));

  always_ff @(posedge i_clk) begin
    if (i_srst || flash_wrap) begin
      flash_cnt <= 32'h0;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flash_phase <= 1'b0;
    end else if (flash_wrap) begin
      flash_phase <= ~flash_phase;
    end
  end

  // Output registers
  wire [7:0] next_bargraph = show_remote ? i_remote_level : bar;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bar <= 8'h00;
    end else begin
      bar <= next_bar;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data <= 32'h0;
    end else begin
      o_rd_data <= rd_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_supply_led <= lsil_pkg::COL_OFF;
    end else begin
      o_supply_led <= next_supply;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_participant_led <= lsil_pkg::COL_OFF;
    end else begin
      o_participant_led <= next_part;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_optical_connection_led <= lsil_pkg::COL_OFF;
    end else begin
      o_optical_connection_led <= next_opt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_link_error_led <= lsil_pkg::COL_OFF;
    end else begin
      o_link_error_led <= next_err;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_wired_link_led <= lsil_pkg::COL_OFF;
    end else begin
      o_wired_link_led <= next_wired;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_receive_level_bargraph <= 8'h00;
    end else begin
      o_receive_level_bargraph <= next_bargraph;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_level_to_remote <= 8'h00;
    end else begin
      o_level_to_remote <= bar;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_quality_warning_output <= 1'b0;
    end else begin
      o_quality_warning_output <= next_warn;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_data_tx_enable <= 1'b0;
    end else begin
      o_data_tx_enable <= next_tx_en && !i_tx_disabled;
    end
  end

endmodule

// ==== pkg/lsil_pkg.sv ====
/*
  Shared constants and types for the link status indicator logic:
  register offsets, reset values, LED colours, operating modes, timing.
  Assumes a 125 MHz system clock.
*/
package lsil_pkg;

  typedef enum logic [1:0] {
    COL_OFF,
    COL_GREEN,
    COL_ORANGE,
    COL_RED
  } lsil_colour_t;

  typedef enum logic [1:0] {
    MODE_SELF_RUNNING,
    MODE_HAND_SET,
    MODE_ALIGNMENT,
    MODE_OTHER
  } lsil_mode_t;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THR_BASE = 8'h04;
  localparam logic [7:0] REG_HYST = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_REMOTE = 8'h2c;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SHOW_REMOTE = 2;

  // Status fields
  localparam int STAT_BAR_LSB = 0;
  localparam int STAT_LINK = 8;
  localparam int STAT_WARN = 9;
  localparam int STAT_TX_EN = 10;

  // Bargraph layout
  localparam int SEG_COUNT = 8;
  localparam int SEG_FIRST_ORANGE = 2;
  localparam int SEG_FIRST_GREEN = 4;

  // Reset values
  localparam logic [7:0] THR_STEP_RST = 8'h1c;
  localparam logic [7:0] HYST_RST = 8'h04;
  localparam lsil_mode_t MODE_RST = MODE_SELF_RUNNING;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int FLASH_HALF_US = 250000;
  localparam int ACT_STRETCH_US = 50000;
  localparam int FLASH_HALF_CYC = FLASH_HALF_US * (1000 / CLK_PERIOD_NS);
  localparam int ACT_STRETCH_CYC = ACT_STRETCH_US * (1000 / CLK_PERIOD_NS);

endpackage

// ==== testbench/lsil_indicator_checker.sv ====
/*
  Concurrent checks on the indicator outputs.
  Assumes binding to lsil_indicator, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module lsil_indicator_checker (
  input logic i_clk,
  input logic i_srst,
  input logic i_rd_en,
  input logic i_tx_disabled,
  input logic i_remote_tx_disabled,
  input logic i_phy_link,
  input logic i_remote_phy_link,
  input logic [31:0] o_rd_data,
  input lsil_pkg::lsil_colour_t o_optical_connection_led,
  input lsil_pkg::lsil_colour_t o_link_error_led,
  input lsil_pkg::lsil_colour_t o_wired_link_led,
  input logic [7:0] o_level_to_remote,
  input logic o_quality_warning_output,
  input logic o_data_tx_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire [7:0] lit = o_level_to_remote;
  property p_rd_idle; !$past(i_rd_en) |-> o_rd_data == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_contig; ((lit + 8'h01) & lit) == 8'h00; endproperty
  a_contig: assert property (p_contig) else $error("bar not contiguous");
  property p_red_warn; !$past(i_srst) && !lit[2] |-> o_quality_warning_output && !o_data_tx_enable; endproperty
  a_red_warn: assert property (p_red_warn) else $error("red only handling");
  property p_green_calm; lit[4] |-> !o_quality_warning_output; endproperty
  a_green_calm: assert property (p_green_calm) else $error("warning with reserve");
  property p_err_red; !$past(i_srst) && !$past(i_phy_link) |-> o_link_error_led == lsil_pkg::COL_RED; endproperty
  a_err_red: assert property (p_err_red) else $error("error led not red");
  property p_err_org; lit[2] && $past(i_phy_link && !i_remote_phy_link) |-> o_link_error_led == lsil_pkg::COL_ORANGE;
  endproperty
  a_err_org: assert property (p_err_org) else $error("error led not orange");
  property p_opt_dark; (!lit[2] || $past(i_tx_disabled || i_remote_tx_disabled))
    |-> o_optical_connection_led == lsil_pkg::COL_OFF; endproperty
  a_opt_dark: assert property (p_opt_dark) else $error("optical led lit");
  property p_wired_off; !$past(i_phy_link) |-> o_wired_link_led == lsil_pkg::COL_OFF; endproperty
  a_wired_off: assert property (p_wired_off) else $error("wired led lit");
  c_full: cover property (lit == 8'hff);
  c_red_only: cover property (lit == 8'h03);
  c_err_org: cover property (o_link_error_led == lsil_pkg::COL_ORANGE);
endmodule
bind lsil_indicator lsil_indicator_checker chk_u (.i_clk, .i_srst, .i_rd_en, .i_tx_disabled, .i_remote_tx_disabled,
  .i_phy_link, .i_remote_phy_link, .o_rd_data, .o_optical_connection_led, .o_link_error_led, .o_wired_link_led,
  .o_level_to_remote, .o_quality_warning_output, .o_data_tx_enable);

// ==== testbench/lsil_far_side.sv ====
/*
  Far-side model: optical level detector and wired PHY.
  Assumes the bench asks for a lit segment count, link and traffic.
*/
`timescale 1ns/1ps
module lsil_far_side (
  input logic i_clk,
  input logic [3:0] i_seg_req,
  input logic i_link_req,
  input logic i_act_req,
  output logic [7:0] o_rx_level = 8'h05,
  output logic o_phy_link = 1'b0,
  output logic o_phy_activity = 1'b0
);
  // Level midway between thresholds, clear of hysteresis
  always @(posedge i_clk) begin
    o_rx_level <= (i_seg_req == 4'h0) ? 8'h05 : 8'(i_seg_req * 8'h1c + 8'h0e);
    o_phy_link <= i_link_req;
    o_phy_activity <= i_act_req && i_link_req;
  end
endmodule

// ==== testbench/lsil_indicator_tb.sv ====
/*
  Self-checking bench of the link status indicator logic.
  Assumes default thresholds and shortened flash and stretch counts.
*/
`timescale 1ns/1ps
module lsil_indicator_tb;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, opt_act = 1'b0, tx_dis = 1'b0, rtx_dis = 1'b0;
  logic rlink = 1'b1, link_req = 1'b1, act_req = 1'b0, rx_link, rx_act, warn, txen;
  logic [4:0] bus = 5'h0;
  logic [7:0] addr = 8'h0, rlev = 8'hff, rx_lev, bar, to_rem;
  logic [3:0] seg = 4'h8;
  logic [31:0] wdata = 32'h0, rdata;
  logic [5:0] o;
  lsil_pkg::lsil_colour_t sup, part, opt, link_error_led, wled;
  int err_count = 0, n_checks = 0, cyc = 0, k, m;
  lsil_indicator #(.LEVEL_W(8), .FLASH_HALF_CYC(4), .ACT_STRETCH_CYC(6)) dut_u (.i_clk(clk), .i_srst(srst),
    .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata), .i_bus_waiting(bus[0]),
    .i_bus_exchange(bus[1]), .i_ident_blink(bus[2]), .i_bus_error(bus[3]), .i_bus_cfg_fail(bus[4]),
    .i_tx_disabled(tx_dis), .i_remote_tx_disabled(rtx_dis), .i_opt_activity(opt_act), .i_phy_link(rx_link),
    .i_phy_activity(rx_act), .i_rx_level(rx_lev), .i_remote_level(rlev), .i_remote_phy_link(rlink),
    .o_supply_led(sup), .o_participant_led(part), .o_optical_connection_led(opt), .o_link_error_led(link_error_led),
    .o_wired_link_led(wled), .o_receive_level_bargraph(bar), .o_level_to_remote(to_rem),
    .o_quality_warning_output(warn), .o_data_tx_enable(txen));
  lsil_far_side far_u (.i_clk(clk), .i_seg_req(seg), .i_link_req(link_req), .i_act_req(act_req),
    .o_rx_level(rx_lev), .o_phy_link(rx_link), .o_phy_activity(rx_act));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic part_chk(input logic [4:0] b, input lsil_pkg::lsil_colour_t c, input logic fl);
    int on = 0;
    int off = 0;
    int sok = 0;
    @(posedge clk);
    bus <= b;
    repeat (19) begin
      @(posedge clk);
      #1 if (part === c) on++; else if (part === lsil_pkg::COL_OFF) off++;
      if (b[2] ? (sup === part || b[4:3] != 2'b00) && (sup === lsil_pkg::COL_ORANGE || sup === lsil_pkg::COL_OFF)
          : sup === lsil_pkg::COL_GREEN) sok++;
    end
    chk(32'({on + off >= 16, on > 0, off > 0}), 32'({2'b11, fl}));
    chk(32'(sok), 32'd19);
  endtask
  function automatic logic [5:0] exp_out(input int k, input int m);
    logic red;
    lsil_pkg::lsil_colour_t e;
    red = (k <= 2);
    e = (!link_req || red) ? lsil_pkg::COL_RED : (!rlink || !rlev[2]) ? lsil_pkg::COL_ORANGE : lsil_pkg::COL_OFF;
    return {red || (k <= 4 && m != 3), !red && (k >= 5 || m == 0) && !tx_dis, e, 2'((red || tx_dis || rtx_dis) ? 0 : 1)};
  endfunction
  initial begin
    void'($urandom(45462));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(8'(lsil_pkg::REG_THR_BASE + 4 * i), 32'((i + 1) * 8'h1c));
    rd_chk(lsil_pkg::REG_HYST, 32'h4);
    rd_chk(8'h30, 32'h0);
    wr_reg(lsil_pkg::REG_STATUS, 32'hffffffff);
    rd_chk(lsil_pkg::REG_STATUS, 32'h5ff);
    part_chk(5'b00001, lsil_pkg::COL_GREEN, 1'b1);
    part_chk(5'b00011, lsil_pkg::COL_GREEN, 1'b0);
    part_chk(5'b00111, lsil_pkg::COL_ORANGE, 1'b1);
    part_chk(5'b01111, lsil_pkg::COL_RED, 1'b0);
    part_chk(5'b11111, lsil_pkg::COL_RED, 1'b1);
    for (int i = 0; i < 60; i++) begin
      k = (i < 36) ? i % 9 : $urandom_range(8);
      m = (i < 36) ? i / 9 : $urandom_range(3);
      wr_reg(lsil_pkg::REG_CTRL, 32'(m + 4 * (i % 2)));
      @(posedge clk);
      seg <= 4'(k);
      link_req <= 1'($urandom);
      rlink <= 1'($urandom);
      rlev <= 8'($urandom);
      tx_dis <= ($urandom_range(3) == 0);
      rtx_dis <= ($urandom_range(3) == 0);
      repeat (5) @(posedge clk);
      #1 o = exp_out(k, m);
      chk(32'(bar), (i % 2) ? 32'(rlev) : 32'((1 << k) - 1));
      chk(32'(to_rem), 32'((1 << k) - 1));
      chk(32'({warn, txen, link_error_led, opt}), 32'(o));
      rd_chk(lsil_pkg::REG_STATUS, 32'({o[4], o[5], k >= 3, 8'((1 << k) - 1)}));
      rd_chk(lsil_pkg::REG_REMOTE, 32'(rlev));
      rd_chk(lsil_pkg::REG_CTRL, 32'(m + 4 * (i % 2)));
    end
    @(posedge clk);
    seg <= 4'h8;
    link_req <= 1'b1;
    tx_dis <= 1'b0;
    rtx_dis <= 1'b0;
    opt_act <= 1'b1;
    act_req <= 1'b1;
    @(posedge clk);
    opt_act <= 1'b0;
    act_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(32'({opt, wled}), 32'ha);
    repeat (12) @(posedge clk);
    #1 chk(32'({opt, wled}), 32'h5);
    @(posedge clk);
    link_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(32'(wled), 32'h0);
    wr_reg(lsil_pkg::REG_HYST, 32'h9);
    wr_reg(lsil_pkg::REG_THR_BASE + 8'h1c, 32'hf0);
    rd_chk(lsil_pkg::REG_HYST, 32'h9);
    rd_chk(lsil_pkg::REG_THR_BASE + 8'h1c, 32'hf0);
    chk(32'(to_rem), 32'hff);
    @(posedge clk);
    seg <= 4'h7;
    repeat (4) @(posedge clk);
    seg <= 4'h8;
    repeat (4) @(posedge clk);
    #1 chk(32'(to_rem), 32'h7f);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(32'({sup, part, opt, link_error_led, wled, bar, to_rem, warn, txen}), 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    rd_chk(lsil_pkg::REG_HYST, 32'h4);
    rd_chk(lsil_pkg::REG_THR_BASE + 8'h1c, 32'he0);
    report_and_stop();
  end
endmodule
